/* File: hdl/iab_consts.svh */
`ifndef IAB_CONSTS_SVH
`define IAB_CONSTS_SVH
// Bank word offsets, byte address = bank*0x40 + word*4
`define IAB_BANK_STRIDE 8'h40
`define IAB_W_MASK 4'h0
`define IAB_W_CASC 4'h1
`define IAB_W_MODE 4'h2
`define IAB_W_CMD 4'h3
`define IAB_W_REQ 4'h4
`define IAB_W_ISR 4'h5
`define IAB_W_VEC0 4'h8
// Mode and command fields
`define IAB_MODE_AUTO_END_OF_SERVICE 0
`define IAB_CMD_NSPEC 3
`define IAB_CMD_SPEC 4
// Reset values
`define IAB_MASK_RST 8'hFF
`define IAB_CASC_RST 8'h00
`define IAB_VEC_RST 8'h00
// Cascade level of lower bank, default vector level
`define IAB_CASC_LVL 3'h2
`define IAB_DEF_LVL 3'h7
// Wait states added in each acknowledge cycle
`define IAB_ACK_WAIT_NS 50
`define IAB_CLK_NS 25
`define IAB_ACK_WAIT_CYC ((`IAB_ACK_WAIT_NS + `IAB_CLK_NS - 1) / `IAB_CLK_NS)
`endif

/* File: hdl/iab_pkg.sv */
package iab_pkg;
  // Acknowledge sequencer states, one-hot
  typedef enum logic [5:0] {
    IAB_IDLE = 6'b000001,
    IAB_WT1 = 6'b000010,
    IAB_RDY1 = 6'b000100,
    IAB_GAP = 6'b001000,
    IAB_WT2 = 6'b010000,
    IAB_RDY2 = 6'b100000
  } iab_state_t;
  typedef logic [7:0] iab_byte_t;
endpackage

/* File: hdl/iab_ctrl.sv */
// Function
// - Output high while any unmasked request not blocked by a service bit pends
// - Two acknowledge cycles, status lines all low
// - First cycle resolves priority, drives zero
// - Second cycle drives selected line vector
// - Cascaded input: first cycle drives vector
// - Cascaded input: second cycle leaves bus
// - Nothing pending: give bank A level 7
// - Wait states added inside each cycle
// - Each bank keeps its own mode
// - Non-specific end clears highest service bit
// - Specific end clears the named bit
// - Auto end clears after second cycle
// - Auto end lets new requests through
// - Level 0 highest, level 7 lowest
// - Acknowledge sets service bit of winner
// - Service bit blocks equal, lower levels
// - One vector register per line
// - Mask blocks line, keeps latched request
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`include "iab_consts.svh"
module iab_ctrl #(
  parameter int NB = 3
) (
  input wire logic clk_sys, // 40 MHz
  input wire logic reset_n, // Sync reset
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready in
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB ready out
  output logic hresp, // Always OKAY
  input wire logic [8*NB-1:0] request_n, // Request lines
  input wire logic mem_io_status, // Memory or I/O
  input wire logic data_code_status, // Data or code
  input wire logic write_read_status, // Write or read
  input wire logic cycle_strobe_n, // Bus cycle active
  output logic int_out, // Interrupt to host
  output iab_pkg::iab_byte_t data_out, // Data bus out
  output logic data_oe, // Data bus enable
  output logic ack_ready_n // Cycle ready
);
  import iab_pkg::*;
  // Pin synchronisers
  logic [8*NB+3:0] s1_reg, s2_reg;
  logic strb_q_reg;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s1_reg <= '1;
      s2_reg <= '1;
      strb_q_reg <= 1'b1;
    end else begin
      s1_reg <= {cycle_strobe_n, mem_io_status, data_code_status, write_read_status, request_n};
      s2_reg <= s1_reg;
      strb_q_reg <= s2_reg[8*NB+3];
    end
  end
  logic ack_start;
  // Acknowledge cycle starts
  assign ack_start = !s2_reg[8*NB+3] && strb_q_reg && (s2_reg[8*NB+2:8*NB] == 3'h0);
  // Register file
  iab_byte_t mask_reg[NB], mask_next[NB], casc_reg[NB], casc_next[NB];
  iab_byte_t isr_reg[NB], isr_next[NB], irr_reg[NB], irr_next[NB];
  iab_byte_t vec_reg[NB][8], vec_next[NB][8];
  logic [NB-1:0] auto_end_of_service_reg, auto_end_of_service_next;
  // Eligible levels under fixed priority
  function automatic iab_byte_t elig_f(input iab_byte_t r, input iab_byte_t m, input iab_byte_t s);
    logic blk;
    blk = 1'b0;
    elig_f = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (s[i]) blk = 1'b1;
      elig_f[i] = r[i] && !m[i] && !blk;
    end
  endfunction
  // Lowest set index is highest priority
  function automatic logic [2:0] first_f(input iab_byte_t v);
    first_f = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) first_f = i[2:0];
    end
  endfunction
  // Cascade chain, lowest bank first
  iab_byte_t eff[NB], elig[NB];
  logic [NB-1:0] bint;
  always_comb begin
    for (int b = NB - 1; b >= 0; b--) begin
      eff[b] = irr_reg[b];
      if (b < NB - 1 && bint[b+1]) eff[b][`IAB_CASC_LVL] = 1'b1;
      elig[b] = elig_f(eff[b], mask_reg[b], isr_reg[b]);
      bint[b] = |elig[b];
    end
  end
  // Walk from bank A down the chain
  logic [NB-1:0] path;
  logic [1:0] wbank;
  logic [2:0] wlvl;
  logic go;
  always_comb begin
    path = '0;
    wbank = 2'h0;
    wlvl = `IAB_DEF_LVL;
    go = bint[0];
    for (int b = 0; b < NB; b++) begin
      if (go) begin
        path[b] = 1'b1;
        wbank = b[1:0];
        wlvl = first_f(elig[b]);
        go = (b < NB - 1) && wlvl == `IAB_CASC_LVL && bint[b+1];
      end
    end
  end
  // Acknowledge sequencer state
  iab_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] sb_reg, sb_next;
  logic [2:0] sl_reg, sl_next;
  logic ext_reg, ext_next, none_reg, none_next;
  logic [NB-1:0] path_reg, path_next;
  iab_byte_t dout_reg, dout_next;
  logic oe_reg, oe_next, rdy_reg, rdy_next, int_reg;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sb_next = sb_reg;
    sl_next = sl_reg;
    ext_next = ext_reg;
    none_next = none_reg;
    path_next = path_reg;
    dout_next = dout_reg;
    oe_next = 1'b0;
    rdy_next = 1'b1;
    unique case (st_reg)
      IAB_IDLE: begin
        if (ack_start) begin
          st_next = IAB_WT1;
          cnt_next = 4'(`IAB_ACK_WAIT_CYC);
          sb_next = wbank;
          sl_next = wlvl;
          none_next = !bint[0];
          ext_next = bint[0] && casc_reg[wbank][wlvl];
          path_next = path;
        end
      end
      IAB_WT1: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          st_next = IAB_RDY1;
          oe_next = 1'b1;
          rdy_next = 1'b0;
          dout_next = ext_reg ? vec_reg[sb_reg][sl_reg] : 8'h00;
        end
      end
      IAB_RDY1: st_next = IAB_GAP;
      IAB_GAP: begin
        if (ack_start) begin
          st_next = IAB_WT2;
          cnt_next = 4'(`IAB_ACK_WAIT_CYC);
        end
      end
      IAB_WT2: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          st_next = IAB_RDY2;
          oe_next = !ext_reg;
          rdy_next = 1'b0;
          dout_next = ext_reg ? 8'h00 : vec_reg[sb_reg][sl_reg];
        end
      end
      IAB_RDY2: st_next = IAB_IDLE;
    endcase
  end
  // AHB-Lite slave, one wait state per transfer
  logic aw_reg, aw_next, rd_reg, rd_next, hrdy_reg, hrdy_next;
  logic [1:0] ab_reg, ab_next;
  logic [3:0] aw_word_reg, aw_word_next;
  logic [31:0] hrd_reg, hrd_next;
  logic take;
  assign take = hsel && htrans[1] && hready;
  always_comb begin
    aw_next = 1'b0;
    hrdy_next = !take; // Low for the one data-phase wait
    rd_next = 1'b0;
    ab_next = ab_reg;
    aw_word_next = aw_word_reg;
    hrd_next = hrd_reg;
    if (take) begin
      aw_next = hwrite;
      rd_next = !hwrite;
      ab_next = haddr[7:6];
      aw_word_next = haddr[5:2];
    end
    if (rd_reg) begin
      hrd_next = 32'h0000_0000;
      if (ab_reg < NB) begin
        unique case (aw_word_reg)
          `IAB_W_MASK: hrd_next[7:0] = mask_reg[ab_reg];
          `IAB_W_CASC: hrd_next[7:0] = casc_reg[ab_reg];
          `IAB_W_MODE: hrd_next[`IAB_MODE_AUTO_END_OF_SERVICE] = auto_end_of_service_reg[ab_reg];
          `IAB_W_REQ: hrd_next[7:0] = irr_reg[ab_reg];
          `IAB_W_ISR: hrd_next[7:0] = isr_reg[ab_reg];
          default: if (aw_word_reg[3]) hrd_next[7:0] = vec_reg[ab_reg][aw_word_reg[2:0]];
        endcase
      end
    end
  end
  // Bank registers: writes, acknowledge, end of service
  always_comb begin
    for (int b = 0; b < NB; b++) begin
      mask_next[b] = mask_reg[b];
      casc_next[b] = casc_reg[b];
      auto_end_of_service_next[b] = auto_end_of_service_reg[b];
      irr_next[b] = ~s2_reg[8*b+:8];
      isr_next[b] = isr_reg[b];
      for (int v = 0; v < 8; v++) vec_next[b][v] = vec_reg[b][v];
      if (aw_reg && ab_reg == b[1:0]) begin
        unique case (aw_word_reg)
          `IAB_W_MASK: mask_next[b] = hwdata[7:0];
          `IAB_W_CASC: casc_next[b] = hwdata[7:0];
          `IAB_W_MODE: auto_end_of_service_next[b] = hwdata[`IAB_MODE_AUTO_END_OF_SERVICE];
          `IAB_W_CMD: begin
            if (hwdata[`IAB_CMD_SPEC]) isr_next[b][hwdata[2:0]] = 1'b0;
            else if (hwdata[`IAB_CMD_NSPEC] && |isr_reg[b])
              isr_next[b][first_f(isr_reg[b])] = 1'b0;
          end
          default: if (aw_word_reg[3]) vec_next[b][aw_word_reg[2:0]] = hwdata[7:0];
        endcase
      end
      // Auto end of service after second cycle
      if (st_reg == IAB_RDY2 && path_reg[b] && auto_end_of_service_reg[b] && |isr_reg[b])
        isr_next[b][first_f(isr_reg[b])] = 1'b0;
      // Set beats a same-cycle clear
      if (st_reg == IAB_IDLE && ack_start && path[b])
        isr_next[b][b == wbank ? wlvl : `IAB_CASC_LVL] = 1'b1;
    end
  end
  // State registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_reg <= IAB_IDLE;
      cnt_reg <= 4'h0;
      sb_reg <= 2'h0;
      sl_reg <= 3'h0;
      ext_reg <= 1'b0;
      none_reg <= 1'b0;
      path_reg <= '0;
      dout_reg <= 8'h00;
      oe_reg <= 1'b0;
      rdy_reg <= 1'b1;
      int_reg <= 1'b0;
      aw_reg <= 1'b0;
      rd_reg <= 1'b0;
      hrdy_reg <= 1'b1;
      ab_reg <= 2'h0;
      aw_word_reg <= 4'h0;
      hrd_reg <= 32'h0000_0000;
      auto_end_of_service_reg <= '0;
      for (int b = 0; b < NB; b++) begin
        mask_reg[b] <= `IAB_MASK_RST;
        casc_reg[b] <= `IAB_CASC_RST;
        isr_reg[b] <= 8'h00;
        irr_reg[b] <= 8'h00;
        for (int v = 0; v < 8; v++) vec_reg[b][v] <= `IAB_VEC_RST;
      end
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sb_reg <= sb_next;
      sl_reg <= sl_next;
      ext_reg <= ext_next;
      none_reg <= none_next;
      path_reg <= path_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      rdy_reg <= rdy_next;
      int_reg <= bint[0];
      aw_reg <= aw_next;
      rd_reg <= rd_next;
      hrdy_reg <= hrdy_next;
      ab_reg <= ab_next;
      aw_word_reg <= aw_word_next;
      hrd_reg <= hrd_next;
      auto_end_of_service_reg <= auto_end_of_service_next;
      mask_reg <= mask_next;
      casc_reg <= casc_next;
      isr_reg <= isr_next;
      irr_reg <= irr_next;
      vec_reg <= vec_next;
    end
  end

  // Outputs
  assign int_out = int_reg;
  assign data_out = dout_reg;
  assign data_oe = oe_reg;
  assign ack_ready_n = rdy_reg;
  assign hrdata = hrd_reg;
  assign hreadyout = hrdy_reg;
  assign hresp = 1'b0;

  // Checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence ack1_s;
    st_reg == IAB_IDLE && ack_start;
  endsequence
  sequence wait1_s;
    st_reg == IAB_WT1 [*2];
  endsequence
  int_follow_a: assert property (bint[0] |=> int_out) else $error("int not raised");
  int_drop_a: assert property (!bint[0] |=> !int_out) else $error("int not dropped");
  ack_wait_a: assert property (ack1_s ##1 wait1_s |=> !ack_ready_n && data_oe)
    else $error("first ready late");
  first_zero_a: assert property (st_reg == IAB_RDY1 && !ext_reg |-> data_out == 8'h00)
    else $error("first byte not zero");
  casc_float_a: assert property (st_reg == IAB_RDY2 && ext_reg |-> !data_oe)
    else $error("bus driven for slave");
  vec_second_a: assert property (st_reg == IAB_RDY2 && !ext_reg |-> data_oe && data_out == vec_reg[sb_reg][sl_reg])
    else $error("wrong vector");
  default_vec_a: assert property ((ack1_s and (!bint[0])) |=> sb_reg == 2'h0 && sl_reg == `IAB_DEF_LVL && none_reg)
    else $error("default vector wrong");
  isr_set_a: assert property ((ack1_s and bint[0]) |=> isr_reg[0][$past(path[0] && wbank == 2'h0 ? wlvl : `IAB_CASC_LVL)])
    else $error("service bit not set");
  mask_block_a: assert property (mask_reg[0] == 8'hFF |=> !int_out) else $error("mask ignored");
  spec_eoi_a: assert property (aw_reg && aw_word_reg == `IAB_W_CMD && hwdata[`IAB_CMD_SPEC]
    && !(st_reg == IAB_IDLE && ack_start) && ab_reg == 2'h1 |=> !isr_reg[1][$past(hwdata[2:0])])
    else $error("specific end failed");
endmodule // iab_ctrl

/* File: test/iab_host.sv */
`timescale 1ns/10ps
// Host side of the acknowledge link
module iab_host (
  input wire logic clk_sys, // System clock
  input wire logic ack_ready_n, // Ready from device
  input wire iab_pkg::iab_byte_t data_out, // Byte from device
  input wire logic data_oe, // Device drives bus
  output logic mem_io_status, // Memory or I/O
  output logic data_code_status, // Data or code
  output logic write_read_status, // Write or read
  output logic cycle_strobe_n // Bus cycle active
);
  import iab_pkg::*;
  // Idle bus: no acknowledge code on the status lines
  initial begin
    {mem_io_status, data_code_status, write_read_status, cycle_strobe_n} = 4'hF;
  end
  // One acknowledge cycle held until ready, then four idle states
  task automatic ack(output iab_byte_t d, output logic oe, output bit ok);
    int i;
    ok = 1'b0;
    d = 8'h00;
    oe = 1'b0;
    {mem_io_status, data_code_status, write_read_status, cycle_strobe_n} <= 4'h0;
    for (i = 0; i < 40 && !ok; i++) begin
      @(posedge clk_sys);
      if (ack_ready_n === 1'b0) begin
        ok = 1'b1;
        d = data_out;
        oe = data_oe;
      end
    end
    {mem_io_status, data_code_status, write_read_status, cycle_strobe_n} <= 4'hF;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // iab_host

/* File: test/iab_ctrl_tb.sv */
`timescale 1ns/10ps
`include "iab_consts.svh"
module iab_ctrl_tb;
  import iab_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hready;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, int_out, data_oe, ack_ready_n;
  logic mem_io_status, data_code_status, write_read_status, cycle_strobe_n;
  logic [23:0] request_n = 24'hFFFFFF;
  iab_byte_t data_out;
  int n_mismatch = 0;
  int tests_run = 0;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;
  always #12.5 clk_sys = ~clk_sys;
  iab_ctrl #(.NB(3)) dut (.*);
  iab_host host (.*);
  // Verdict and end of run
  task automatic finish_test;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tmo;
    n_mismatch++;
    $display("[FAIL] wait exp done got timeout");
    finish_test();
  endtask
  // Bounded wait for bus ready at a rising edge
  task automatic wrdy;
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) tmo();
  endtask
  // Single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input int b, input logic [3:0] r, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    htrans <= 2'h2;
    haddr <= 32'(b) * 32'(`IAB_BANK_STRIDE) + 32'(r) * 32'h4;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wrdy();
    rd = hrdata;
  endtask
  task automatic rdc(input string nm, input int b, input logic [3:0] r, input logic [31:0] e);
    ahb(1'b0, b, r, 32'h0);
    chk(nm, e, rd);
  endtask
  // Lets request pins pass the synchroniser, then waits for the level
  task automatic wint(input logic e);
    int i;
    repeat (5) @(posedge clk_sys);
    for (i = 0; i < 8 && int_out !== e; i++) @(posedge clk_sys);
    chk("int_out", {31'h0, e}, {31'h0, int_out});
  endtask
  // Two acknowledge cycles with expected bytes
  task automatic ack2(input logic [7:0] e1, input logic [7:0] e2, input logic oe2);
    iab_byte_t d;
    logic oe;
    bit ok;
    host.ack(d, oe, ok);
    if (!ok) tmo();
    chk("ack1 oe", 32'h1, {31'h0, oe});
    chk("ack1 byte", {24'h0, e1}, {24'h0, d});
    host.ack(d, oe, ok);
    if (!ok) tmo();
    chk("ack2 oe", {31'h0, oe2}, {31'h0, oe});
    if (oe2) chk("ack2 byte", {24'h0, e2}, {24'h0, d});
  endtask
  // Nonzero vector per bank and level
  function automatic logic [7:0] vec(input int b, input int l);
    return 8'(8'h40 + b * 8 + l);
  endfunction
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc("mask A", 0, `IAB_W_MASK, 32'hFF);
    rdc("casc A", 0, `IAB_W_CASC, 32'h0);
    rdc("vec A0", 0, `IAB_W_VEC0, 32'h0);
    rdc("unmapped", 0, 4'h6, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    for (int b = 0; b < 3; b++) begin
      for (int l = 0; l < 8; l++) ahb(1'b1, b, `IAB_W_VEC0 + 4'(l), {24'h0, vec(b, l)});
    end
    rdc("vec C7", 2, 4'hF, {24'h0, vec(2, 7)});
    request_n[3] <= 1'b0;
    request_n[5] <= 1'b0;
    wint(1'b0);
    rdc("req A", 0, `IAB_W_REQ, 32'h28);
    ahb(1'b1, 0, `IAB_W_MASK, 32'h0);
    wint(1'b1);
    ack2(8'h00, vec(0, 3), 1'b1);
    rdc("isr A", 0, `IAB_W_ISR, 32'h08);
    wint(1'b0);
    request_n[1] <= 1'b0;
    wint(1'b1);
    ack2(8'h00, vec(0, 1), 1'b1);
    ahb(1'b1, 0, `IAB_W_CMD, 32'h08);
    rdc("isr A", 0, `IAB_W_ISR, 32'h08);
    request_n[1] <= 1'b1;
    request_n[3] <= 1'b1;
    ahb(1'b1, 0, `IAB_W_CMD, 32'h13);
    rdc("isr A", 0, `IAB_W_ISR, 32'h00);
    wint(1'b1);
    ack2(8'h00, vec(0, 5), 1'b1);
    request_n[5] <= 1'b1;
    ahb(1'b1, 0, `IAB_W_CMD, 32'h15);
    ahb(1'b1, 1, `IAB_W_MASK, 32'h0);
    request_n[12] <= 1'b0;
    wint(1'b1);
    ack2(8'h00, vec(1, 4), 1'b1);
    rdc("isr A", 0, `IAB_W_ISR, 32'h04);
    request_n[12] <= 1'b1;
    ahb(1'b1, 1, `IAB_W_CMD, 32'h14);
    ahb(1'b1, 0, `IAB_W_CMD, 32'h08);
    rdc("isr B", 1, `IAB_W_ISR, 32'h00);
    ahb(1'b1, 0, `IAB_W_CASC, 32'h40);
    request_n[6] <= 1'b0;
    wint(1'b1);
    ack2(vec(0, 6), 8'h00, 1'b0);
    request_n[6] <= 1'b1;
    ahb(1'b1, 0, `IAB_W_CMD, 32'h16);
    wint(1'b0);
    ack2(8'h00, vec(0, 7), 1'b1);
    rdc("isr A", 0, `IAB_W_ISR, 32'h00);
    ahb(1'b1, 0, `IAB_W_MODE, 32'h01);
    request_n[4] <= 1'b0;
    request_n[5] <= 1'b0;
    wint(1'b1);
    ack2(8'h00, vec(0, 4), 1'b1);
    rdc("isr A", 0, `IAB_W_ISR, 32'h00);
    request_n[4] <= 1'b1;
    wint(1'b1);
    rdc("mode B", 1, `IAB_W_MODE, 32'h0);
    finish_test();
  end
endmodule // iab_ctrl_tb
